//--- ess_regs.svh
`ifndef ESS_REGS_SVH
`define ESS_REGS_SVH

// ********************
// register byte offsets
// ********************
`define ESS_A_CMD 10'h000
`define ESS_A_STATUS 10'h004
`define ESS_A_IRQ_STAT 10'h008
`define ESS_A_IRQ_MASK 10'h00C
`define ESS_A_CFG 10'h010
`define ESS_A_PRESS 10'h014
`define ESS_TBL_BIT 9

// ********************
// fields
// ********************
`define ESS_F_MODE 3'h0
`define ESS_F_ACCEL 3'h1
`define ESS_F_DECEL 3'h2
`define ESS_F_SPEED 3'h3
`define ESS_F_VALUE 3'h4
`define ESS_F_CTRL 3'h5
`define ESS_F_LVAL 3'h6
`define ESS_LINK_END 2'h0
`define ESS_LINK_DELAY 2'h1
`define ESS_LINK_BITS 2'h2
`define ESS_LINK_BITS2 2'h3
`define ESS_MODE_CALC_RAMP 4
`define ESS_MODE_MONITOR 8
`define ESS_CFG_PRESS_AXIS 0
`define ESS_CFG_ASSIGNED 1
`define ESS_IRQ_DONE 0
`define ESS_IRQ_REFUSED 1
`define ESS_IRQ_REGUL 2
`define ESS_IRQ_RST 3'h0
`define ESS_CFG_RST 2'h0

// ********************
// timing
// ********************
`define ESS_CLK_NS 8
`define ESS_MS_NS 1000000
`define ESS_CALC_RAMP_MS 16'h0064
`endif

//--- ess_pkg.sv
package ess_pkg;
  typedef enum logic [3:0] {
    ESS_OP_NONE,
    ESS_OP_INIT,
    ESS_OP_NULL_DRV,
    ESS_OP_MOVE,
    ESS_OP_SET_PRESS,
    ESS_OP_SET_MODE,
    ESS_OP_OPEN_LOOP,
    ESS_OP_START,
    ESS_OP_QUIT
  } ess_op_e;

  typedef enum logic [2:0] {
    ESS_ST_IDLE,
    ESS_ST_ISSUE,
    ESS_ST_DELAY,
    ESS_ST_WAIT_POS,
    ESS_ST_WAIT_PRS
  } ess_state_e;

  typedef struct packed {
    logic to_press;
    ess_op_e op;
    logic [15:0] mode;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] speed;
    logic [15:0] value;
  } ess_cmd_s;
endpackage

//--- ess_ms_tick.sv
`timescale 1ns/10ps
`default_nettype none
module ess_ms_tick #(
  parameter int CYC = 125000
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_restart,
  output logic o_tick
);
  localparam int CW = $clog2(CYC);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);
  logic [CW-1:0] cnt_r;

  // restart keeps a delay from ending a fraction of a ms early
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
    end else if (i_restart || cnt_r == LAST) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign o_tick = (cnt_r == LAST) && !i_restart;
endmodule
`default_nettype wire

//--- ess_press_ramp.sv
`timescale 1ns/10ps
`default_nettype none
module ess_press_ramp (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic [15:0] i_start,
  input wire logic [15:0] i_goal,
  input wire logic [15:0] i_ms,
  input wire logic i_tick,
  output logic [15:0] o_target
);
  logic [15:0] goal_r;
  logic [15:0] left_r;
  logic signed [17:0] diff;
  logic signed [17:0] stepv;

  always_comb begin
    diff = $signed({2'b00, goal_r}) - $signed({2'b00, o_target});
    stepv = diff / $signed({2'b00, left_r});
  end

  // linear ramp: each ms closes 1/left of the remaining gap
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_target <= '0;
      goal_r <= '0;
      left_r <= '0;
    end else if (i_load) begin
      o_target <= (i_ms == 16'h0000) ? i_goal : i_start;
      goal_r <= i_goal;
      left_r <= i_ms;
    end else if (i_tick && left_r != 16'h0000) begin
      o_target <= o_target + stepv[15:0];
      left_r <= left_r - 16'h0001;
    end
  end
endmodule
`default_nettype wire

//--- ess_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "ess_regs.svh"
module ess_sequencer #(
  parameter int STEPS = 16,
  parameter int CYC_PER_MS = `ESS_MS_NS / `ESS_CLK_NS
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [15:0] i_pos_status,
  input wire logic [15:0] i_press_status,
  input wire logic [15:0] i_meas_press,
  input wire logic [15:0] i_int_drive,
  output ess_pkg::ess_cmd_s o_cmd,
  output logic o_cmd_vld,
  output logic o_hold_pos,
  output logic o_press_reg,
  output logic [15:0] o_null_drive,
  output logic [15:0] o_target_press,
  output logic o_irq
);
  localparam int SW = $clog2(STEPS);

  // ********************
  // storage and state
  // ********************
  logic [15:0] tbl_r [0:STEPS*8-1];
  ess_pkg::ess_state_e st_r;
  logic [SW-1:0] cur_r;
  logic [15:0] dly_r;
  logic init_r;
  logic monit_r;
  logic [15:0] p_mode_r;
  logic [15:0] ramp_r;
  logic [15:0] set_a_r;
  logic [15:0] set_b_r;
  logic [15:0] p_goal_r;
  logic [2:0] irq_st_r;
  logic [2:0] irq_msk_r;
  logic [1:0] cfg_r;
  logic [31:0] last_cmd_r;
  logic rd_done_r;

  // ********************
  // bus decode
  // ********************
  logic rd_acc;
  logic wr_acc;
  logic is_tbl;
  logic [SW+2:0] bus_idx;
  logic host_cmd;
  ess_pkg::ess_op_e host_op;
  logic [15:0] host_val;

  // reads take one wait cycle; writes stall while a step issues
  assign o_avs_waitrequest = (i_avs_read && !rd_done_r) ||
    (i_avs_write && st_r == ess_pkg::ESS_ST_ISSUE);
  assign rd_acc = i_avs_read && !o_avs_waitrequest;
  assign wr_acc = i_avs_write && !o_avs_waitrequest;
  assign is_tbl = i_avs_address[`ESS_TBL_BIT];
  assign bus_idx = {i_avs_address[SW+4:5], i_avs_address[4:2]};
  assign host_cmd = wr_acc && !is_tbl &&
    i_avs_address == `ESS_A_CMD;
  assign host_op = ess_pkg::ess_op_e'(i_avs_writedata[3:0]);
  assign host_val = i_avs_writedata[31:16];

  // ********************
  // current step fields
  // ********************
  logic [15:0] s_ctrl;
  logic [15:0] s_lval;
  logic [1:0] s_link;
  logic [SW-1:0] s_next;
  ess_pkg::ess_cmd_s step_cmd;

  assign s_ctrl = tbl_r[{cur_r, `ESS_F_CTRL}];
  assign s_lval = tbl_r[{cur_r, `ESS_F_LVAL}];
  assign s_link = s_ctrl[5:4];
  assign s_next = s_ctrl[SW+7:8];

  always_comb begin
    step_cmd.op = ess_pkg::ess_op_e'(s_ctrl[3:0]);
    step_cmd.mode = tbl_r[{cur_r, `ESS_F_MODE}];
    step_cmd.accel = tbl_r[{cur_r, `ESS_F_ACCEL}];
    step_cmd.decel = tbl_r[{cur_r, `ESS_F_DECEL}];
    step_cmd.speed = tbl_r[{cur_r, `ESS_F_SPEED}];
    step_cmd.value = tbl_r[{cur_r, `ESS_F_VALUE}];
    step_cmd.to_press = 1'b0;
  end

  // ********************
  // command execution
  // ********************
  ess_pkg::ess_cmd_s ex_cmd;
  logic ex_vld;
  logic ex_ok;
  logic ex_ref;
  logic start_ok;
  logic quit;

  always_comb begin
    ex_cmd = '0;
    ex_vld = 1'b0;
    if (st_r == ess_pkg::ESS_ST_ISSUE && cur_r != '0) begin
      ex_cmd = step_cmd;
      ex_vld = step_cmd.op != ess_pkg::ESS_OP_NONE;
    end else if (host_cmd && host_op != ess_pkg::ESS_OP_START &&
        host_op != ess_pkg::ESS_OP_QUIT &&
        host_op != ess_pkg::ESS_OP_NONE) begin
      ex_cmd.op = host_op;
      ex_cmd.value = host_val;
      ex_vld = 1'b1;
    end
    // only set-pressure counts as a pressure command here, so
    // mode, open-loop and init never leave the position axis
    ex_cmd.to_press = ex_cmd.op == ess_pkg::ESS_OP_SET_PRESS &&
      cfg_r[`ESS_CFG_ASSIGNED];
  end

  assign ex_ref = ex_vld && !init_r &&
    ex_cmd.op != ess_pkg::ESS_OP_INIT;
  assign ex_ok = ex_vld && !ex_ref;
  assign start_ok = host_cmd && host_op == ess_pkg::ESS_OP_START &&
    init_r && !cfg_r[`ESS_CFG_PRESS_AXIS];
  assign quit = host_cmd && host_op == ess_pkg::ESS_OP_QUIT;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmd <= '0;
      o_cmd_vld <= 1'b0;
    end else begin
      o_cmd_vld <= ex_ok;
      if (ex_ok) begin
        o_cmd <= ex_cmd;
      end
    end
  end

  // ********************
  // step sequencer
  // ********************
  logic ms_tick;
  logic done_ev;
  logic link_met;

  ess_ms_tick #(
    .CYC(CYC_PER_MS)
  ) u_tick (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_restart(st_r == ess_pkg::ESS_ST_ISSUE),
    .o_tick(ms_tick)
  );

  always_comb begin
    case (st_r)
      ess_pkg::ESS_ST_DELAY: link_met = dly_r == 16'h0000;
      ess_pkg::ESS_ST_WAIT_POS:
        link_met = (i_pos_status & s_lval) == s_lval;
      ess_pkg::ESS_ST_WAIT_PRS:
        link_met = (i_press_status & s_lval) == s_lval;
      default: link_met = 1'b0;
    endcase
  end

  assign done_ev = (quit && st_r != ess_pkg::ESS_ST_IDLE) ||
    (st_r == ess_pkg::ESS_ST_ISSUE &&
    (cur_r == '0 || s_link == `ESS_LINK_END));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= ess_pkg::ESS_ST_IDLE;
      cur_r <= '0;
      dly_r <= '0;
    end else if (quit) begin
      st_r <= ess_pkg::ESS_ST_IDLE;
      cur_r <= '0;
    end else if (start_ok) begin
      cur_r <= host_val[SW-1:0];
      st_r <= ess_pkg::ESS_ST_ISSUE;
    end else begin
      case (st_r)
        ess_pkg::ESS_ST_IDLE: begin
          st_r <= ess_pkg::ESS_ST_IDLE;
        end
        ess_pkg::ESS_ST_ISSUE: begin
          if (cur_r == '0) begin
            st_r <= ess_pkg::ESS_ST_IDLE;
          end else begin
            case (s_link)
              `ESS_LINK_DELAY: begin
                dly_r <= s_lval;
                st_r <= ess_pkg::ESS_ST_DELAY;
              end
              `ESS_LINK_BITS: st_r <= ess_pkg::ESS_ST_WAIT_POS;
              `ESS_LINK_BITS2: st_r <= ess_pkg::ESS_ST_WAIT_PRS;
              default: begin
                cur_r <= '0;
                st_r <= ess_pkg::ESS_ST_IDLE;
              end
            endcase
          end
        end
        ess_pkg::ESS_ST_DELAY,
        ess_pkg::ESS_ST_WAIT_POS,
        ess_pkg::ESS_ST_WAIT_PRS: begin
          if (link_met) begin
            // a loop of links simply keeps running
            cur_r <= s_next;
            st_r <= ess_pkg::ESS_ST_ISSUE;
          end else if (st_r == ess_pkg::ESS_ST_DELAY && ms_tick) begin
            dly_r <= dly_r - 16'h0001;
          end
        end
        default: st_r <= ess_pkg::ESS_ST_IDLE;
      endcase
    end
  end

  // ********************
  // axis and pressure state
  // ********************
  logic reg_entry;
  logic ramp_go;
  logic calc_ramp;
  logic [15:0] ramp_ms;
  logic [15:0] ramp_goal;
  logic is_op_sp;

  assign is_op_sp = ex_ok && ex_cmd.op == ess_pkg::ESS_OP_SET_PRESS;
  assign reg_entry = monit_r && !o_press_reg &&
    i_meas_press >= set_a_r;
  assign ramp_go = reg_entry || (is_op_sp && o_press_reg);
  assign calc_ramp = is_op_sp ? ex_cmd.mode[`ESS_MODE_CALC_RAMP] :
    p_mode_r[`ESS_MODE_CALC_RAMP];
  assign ramp_goal = is_op_sp ? ex_cmd.value : p_goal_r;
  assign ramp_ms = calc_ramp ? `ESS_CALC_RAMP_MS :
    (is_op_sp ? ex_cmd.speed : ramp_r);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      init_r <= 1'b0;
      o_hold_pos <= 1'b0;
      o_null_drive <= '0;
    end else if (ex_ok) begin
      case (ex_cmd.op)
        ess_pkg::ESS_OP_INIT: begin
          init_r <= 1'b1;
          o_hold_pos <= 1'b1;
        end
        ess_pkg::ESS_OP_NULL_DRV: o_null_drive <= i_int_drive;
        ess_pkg::ESS_OP_MOVE,
        ess_pkg::ESS_OP_OPEN_LOOP: o_hold_pos <= 1'b0;
        default: o_hold_pos <= o_hold_pos;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      p_mode_r <= '0;
      set_a_r <= '0;
      set_b_r <= '0;
      ramp_r <= '0;
      p_goal_r <= '0;
    end else if (is_op_sp) begin
      // loads parameters only; regulation is entered elsewhere
      p_mode_r <= ex_cmd.mode;
      set_a_r <= ex_cmd.accel;
      set_b_r <= ex_cmd.decel;
      ramp_r <= ex_cmd.speed;
      p_goal_r <= ex_cmd.value;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      monit_r <= 1'b0;
      o_press_reg <= 1'b0;
    end else if (ex_ok && (ex_cmd.op == ess_pkg::ESS_OP_INIT ||
        ex_cmd.op == ess_pkg::ESS_OP_OPEN_LOOP)) begin
      monit_r <= 1'b0;
      o_press_reg <= 1'b0;
    end else if (ex_ok && ex_cmd.op == ess_pkg::ESS_OP_MOVE) begin
      monit_r <= ex_cmd.mode[`ESS_MODE_MONITOR];
      o_press_reg <= o_press_reg && ex_cmd.mode[`ESS_MODE_MONITOR];
    end else if (reg_entry) begin
      o_press_reg <= 1'b1;
    end
  end

  ess_press_ramp u_ramp (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_load(ramp_go),
    .i_start(reg_entry ? i_meas_press : o_target_press),
    .i_goal(ramp_goal),
    .i_ms(ramp_ms),
    .i_tick(ms_tick),
    .o_target(o_target_press)
  );

  // ********************
  // registers and interrupt
  // ********************
  logic [2:0] ev;
  logic irq_clr;

  assign ev = {reg_entry, ex_ref || (host_cmd &&
    host_op == ess_pkg::ESS_OP_START && !start_ok), done_ev};
  assign irq_clr = rd_acc && !is_tbl &&
    i_avs_address == `ESS_A_IRQ_STAT;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_st_r <= `ESS_IRQ_RST;
    end else begin
      // an event in the clearing cycle survives
      irq_st_r <= (irq_st_r & {3{!irq_clr}}) | ev;
    end
  end

  assign o_irq = |(irq_st_r & irq_msk_r);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_msk_r <= `ESS_IRQ_RST;
      cfg_r <= `ESS_CFG_RST;
      last_cmd_r <= '0;
    end else if (wr_acc && !is_tbl) begin
      case (i_avs_address)
        `ESS_A_IRQ_MASK: irq_msk_r <= i_avs_writedata[2:0];
        `ESS_A_CFG: cfg_r <= i_avs_writedata[1:0];
        `ESS_A_CMD: last_cmd_r <= i_avs_writedata;
        default: cfg_r <= cfg_r;
      endcase
    end
  end

  // table has no reset: contents are software's to load
  always_ff @(posedge i_clk) begin
    if (wr_acc && is_tbl) begin
      if (i_avs_byteenable[0]) begin
        tbl_r[bus_idx][7:0] <= i_avs_writedata[7:0];
      end
      if (i_avs_byteenable[1]) begin
        tbl_r[bus_idx][15:8] <= i_avs_writedata[15:8];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_done_r <= 1'b0;
      o_avs_readdata <= '0;
    end else begin
      rd_done_r <= i_avs_read && !rd_done_r;
      if (i_avs_read && !rd_done_r) begin
        o_avs_readdata <= '0;
        if (is_tbl) begin
          o_avs_readdata[15:0] <= tbl_r[bus_idx];
        end else begin
          case (i_avs_address)
            `ESS_A_CMD: o_avs_readdata <= last_cmd_r;
            `ESS_A_STATUS: o_avs_readdata <= {16'h0000,
              8'(cur_r), 1'b0, st_r, o_press_reg, monit_r,
              o_hold_pos, init_r};
            `ESS_A_IRQ_STAT: o_avs_readdata[2:0] <= irq_st_r;
            `ESS_A_IRQ_MASK: o_avs_readdata[2:0] <= irq_msk_r;
            `ESS_A_CFG: o_avs_readdata[1:0] <= cfg_r;
            `ESS_A_PRESS: o_avs_readdata <= {o_null_drive,
              o_target_press};
            default: o_avs_readdata <= '0;
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- ess_sequencer_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ess_sequencer_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic [31:0] o_avs_readdata,
  input wire logic [15:0] i_int_drive,
  input wire ess_pkg::ess_cmd_s o_cmd,
  input wire logic o_cmd_vld,
  input wire logic o_hold_pos,
  input wire logic [15:0] o_null_drive
);
  logic init_seen_r;
  // ********************
  // helper and checks
  // ********************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      init_seen_r <= 1'b0;
    end else if (o_cmd_vld && o_cmd.op == ess_pkg::ESS_OP_INIT) begin
      init_seen_r <= 1'b1;
    end
  end
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_read_one_wait: assert property ($rose(i_avs_read) |->
    o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("read wait");
  a_write_accept: assert property (i_avs_write |->
    ##[0:1] !o_avs_waitrequest) else $error("write wait");
  a_rdata_stands: assert property (!i_avs_read |=>
    $stable(o_avs_readdata)) else $error("readdata moved");
  a_init_first: assert property (o_cmd_vld |->
    init_seen_r || o_cmd.op == ess_pkg::ESS_OP_INIT) else $error("no init");
  a_route_press: assert property (o_cmd_vld && o_cmd.to_press |->
    o_cmd.op == ess_pkg::ESS_OP_SET_PRESS) else $error("bad route");
  a_stay_local: assert property (o_cmd_vld && o_cmd.op inside
    {ess_pkg::ESS_OP_INIT, ess_pkg::ESS_OP_SET_MODE,
    ess_pkg::ESS_OP_OPEN_LOOP} |-> !o_cmd.to_press) else $error("routed");
  a_init_holds: assert property (o_cmd_vld &&
    o_cmd.op == ess_pkg::ESS_OP_INIT |-> ##[0:1] o_hold_pos)
    else $error("no hold");
  a_null_copy: assert property ($changed(o_null_drive) |->
    o_null_drive == $past(i_int_drive)) else $error("null value");
  a_null_cause: assert property ($changed(o_null_drive) |->
    o_cmd.op == ess_pkg::ESS_OP_NULL_DRV) else $error("null cause");
endmodule
bind ess_sequencer ess_sequencer_chk u_chk (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest),
  .o_avs_readdata(o_avs_readdata),
  .i_int_drive(i_int_drive),
  .o_cmd(o_cmd),
  .o_cmd_vld(o_cmd_vld),
  .o_hold_pos(o_hold_pos),
  .o_null_drive(o_null_drive)
);
`default_nettype wire

//--- ess_axis_model.sv
`timescale 1ns/10ps
`default_nettype none
module ess_axis_model #(
  parameter int DLY = 15
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire ess_pkg::ess_cmd_s i_cmd,
  input wire logic i_cmd_vld,
  output logic [15:0] o_pos_status,
  output logic [15:0] o_press_status,
  output logic [15:0] o_meas_press,
  output logic [15:0] o_int_drive
);
  logic [7:0] cnt_r;
  logic [4:0] left_r;
  logic inpos_r;
  logic [15:0] goal_r;
  // ********************
  // axis behaviour
  // ********************
  // spare bits 15:8 and position bit 0 toggle, so only the selected bit can release a wait
  assign o_pos_status = {cnt_r, 6'h00, inpos_r, cnt_r[0]};
  assign o_meas_press = {8'h00, cnt_r};
  assign o_press_status = {cnt_r, 7'h00, o_meas_press >= goal_r};
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 8'h00;
      left_r <= 5'h00;
      inpos_r <= 1'b0;
      goal_r <= 16'hFFFF;
      o_int_drive <= 16'h1234;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      if (i_cmd_vld) begin
        inpos_r <= 1'b0;
        o_int_drive <= {o_int_drive[14:0], o_int_drive[15] ^ o_int_drive[13]};
        left_r <= (i_cmd.op == ess_pkg::ESS_OP_MOVE) ? 5'(DLY) : 5'h00;
        if (i_cmd.to_press) begin
          goal_r <= i_cmd.value;
        end
      end else if (left_r != 5'h00) begin
        left_r <= left_r - 5'h01;
        inpos_r <= (left_r == 5'h01);
      end
    end
  end
endmodule
`default_nettype wire

//--- ess_sequencer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ess_regs.svh"
module ess_sequencer_tb_top;
  logic i_clk = 1'b0, i_rst_n = 1'b0, a_rd = 1'b0, a_wr = 1'b0, wq = 1'b1;
  logic [9:0] a_adr = 10'h000;
  logic [31:0] a_wd = 32'h0, rq, rd_q, rs = 32'h38, r;
  logic [31:0] rdata;
  logic [15:0] ps, prs, mp, idrv, nd, tp, v, iv;
  logic waitreq, vld, hold, preg, irq;
  ess_pkg::ess_cmd_s cmd;
  logic [84:0] eq[$];
  int tq[$], cyc = 0, miscompares = 0, n_checks = 0;
  logic [111:0] s1, s2, s3, s5;
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;
  always @(negedge i_clk) begin
    wq = waitreq;
    rq = rdata;
  end
  ess_sequencer #(.CYC_PER_MS(10)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_avs_address(a_adr), .i_avs_read(a_rd), .i_avs_write(a_wr),
    .i_avs_byteenable(4'hF), .i_avs_writedata(a_wd), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_pos_status(ps), .i_press_status(prs),
    .i_meas_press(mp), .i_int_drive(idrv), .o_cmd(cmd), .o_cmd_vld(vld),
    .o_hold_pos(hold), .o_press_reg(preg), .o_null_drive(nd),
    .o_target_press(tp), .o_irq(irq));
  ess_axis_model u_axis (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd(cmd),
    .i_cmd_vld(vld), .o_pos_status(ps), .o_press_status(prs),
    .o_meas_press(mp), .o_int_drive(idrv));
  // ********************
  // checking and bus tasks
  // ********************
  task automatic chk(input logic [95:0] s, input logic [95:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    a_adr <= a;
    a_wr <= w;
    a_rd <= !w;
    a_wd <= d;
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (wq === 1'b0) break;
    end
    rd_q = rq;
    a_wr <= 1'b0;
    a_rd <= 1'b0;
    if (n == 40) begin
      miscompares++;
      end_sim();
    end
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask
  task automatic st(input logic [3:0] s, input logic [111:0] f);
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, 10'h200 + {s, 5'h00} + 10'(i * 4), {16'h0, f[16*(6-i) +: 16]});
    end
  endtask
  task automatic wait_q();
    int n;
    for (n = 0; n < 400 && eq.size() != 0; n++) @(posedge i_clk);
    if (n == 400) begin
      miscompares++;
      end_sim();
    end
  endtask
  task automatic to_idle();
    int n;
    for (n = 0; n < 60; n++) begin
      bus(1'b0, `ESS_A_STATUS, 32'h0);
      if (rd_q[6:4] === 3'h0) break;
    end
    if (n == 60) begin
      miscompares++;
      end_sim();
    end
  endtask
  function automatic logic [84:0] ex(input logic p, input logic [111:0] f);
    return {p, f[19:16], f[111:32]};
  endfunction
  always @(posedge i_clk) begin
    if (vld === 1'b1) begin
      tq.push_back(cyc);
      if (eq.size() == 0) chk(cmd, '1);
      else chk(cmd, eq.pop_front());
    end
  end
  // ********************
  // scenarios
  // ********************
  initial begin
    s1 = {64'h0000_0064_0064_2710, 48'h8CA0_0223_0002};
    s2 = {64'h0010_03E8_01F4_00C8, 48'h1388_0314_0002};
    s3 = {64'h0, 48'h0000_0001_0000};
    s5 = {64'h0001_0000_0000_0000, 48'h00AA_0515_0001};
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(`ESS_A_STATUS, 32'h0);
    rd(10'h01C, 32'h0);
    bus(1'b1, `ESS_A_IRQ_MASK, 32'h7);
    bus(1'b1, `ESS_A_CMD, 32'h3);
    bus(1'b1, `ESS_A_CMD, 32'h0001_0007);
    @(negedge i_clk);
    chk(irq, 1'b1);
    rd(`ESS_A_IRQ_STAT, 32'h2);
    @(negedge i_clk);
    chk(irq, 1'b0);
    for (int op = 1; op <= 6; op++) begin
      r = xs();
      v = r[15:0];
      if (op == 3) iv = idrv;
      eq.push_back({1'b0, 4'(op), 64'h0, v});
      bus(1'b1, `ESS_A_CMD, {v, 12'h000, 4'(op)});
    end
    wait_q();
    chk(nd, iv);
    st(4'h1, s1);
    st(4'h2, s2);
    st(4'h3, s3);
    st(4'h5, s5);
    bus(1'b1, `ESS_A_CFG, 32'h2);
    eq.push_back(ex(1'b0, s1));
    eq.push_back(ex(1'b1, s2));
    eq.push_back(ex(1'b0, s3));
    tq.delete();
    bus(1'b1, `ESS_A_CMD, 32'h0001_0007);
    wait_q();
    to_idle();
    chk(tq[1] - tq[0] >= 15, 1'b1);
    chk(tq[2] - tq[1] >= 20 && tq[2] - tq[1] <= 30, 1'b1);
    rd(`ESS_A_IRQ_STAT, 32'h1);
    bus(1'b1, `ESS_A_CMD, 32'h0000_0007);
    rd(`ESS_A_IRQ_STAT, 32'h1);
    repeat (3) eq.push_back(ex(1'b0, s5));
    bus(1'b1, `ESS_A_CMD, 32'h0005_0007);
    wait_q();
    bus(1'b1, `ESS_A_CMD, 32'h8);
    to_idle();
    repeat (30) @(posedge i_clk);
    chk(eq.size(), 0);
    bus(1'b1, `ESS_A_IRQ_STAT, 32'h0);
    rd(`ESS_A_IRQ_STAT, 32'h1);
    bus(1'b1, `ESS_A_CFG, 32'h1);
    bus(1'b1, `ESS_A_CMD, 32'h0001_0007);
    rd(`ESS_A_IRQ_STAT, 32'h2);
    end_sim();
  end
endmodule
`default_nettype wire
